// ---- hw/ofdr_pkg.sv ----
// package: constants, register map and types of the oscillator failure detect and recovery block
`default_nettype none
package ofdr_pkg;
  // -----------------------------------------------------------------
  // timing
  // -----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100; // system clock period, 10 mhz
  localparam int PRIM_FAIL_PERIOD_NS = 1000000; // 1 khz threshold period in ns
  // longest time: rounds down to whole cycles
  localparam logic [15:0] PRIM_FAIL_CYC_DFLT = 16'(PRIM_FAIL_PERIOD_NS / CLK_PERIOD_NS);
  localparam logic [15:0] WDT_FAIL_CYC_DFLT = 16'h1f44; // 8004 system clocks without a wdt edge
  localparam logic [3:0] SWITCH_GAP_CYC = 4'h4; // clock-off gap during a source change
  localparam int CNT_W = 16; // width of the failure counters

  // -----------------------------------------------------------------
  // register map (byte addresses, one word each)
  // -----------------------------------------------------------------
  localparam logic [7:0] ADR_CTRL = 8'h00; // oscillator_control_reg, read/write
  localparam logic [7:0] ADR_STAT = 8'h04; // sticky failure status, read only
  localparam logic [7:0] ADR_CLR = 8'h08; // write one to clear status
  localparam logic [7:0] ADR_IEN = 8'h0c; // interrupt enable, same layout as status
  localparam logic [7:0] ADR_STATE = 8'h10; // live switch-over state, read only
  localparam int CTRL_W = 6; // used bits of the control register
  localparam int STAT_W = 2; // used bits of status, clear and enable
  localparam int STATE_W = 5; // used bits of the state register
  localparam logic [CTRL_W-1:0] CTRL_RST = 6'h30; // ipo and wdt osc on, detectors off, ipo selected
  localparam logic [STAT_W-1:0] STAT_RST = 2'h0; // nothing pending
  localparam logic [STAT_W-1:0] IEN_RST = 2'h0; // interrupt line masked

  // -----------------------------------------------------------------
  // types
  // -----------------------------------------------------------------
  typedef enum logic [1:0] {
    SRC_IPO = 2'b00, // internal_precision_osc
    SRC_XTAL = 2'b01, // crystal or resonator oscillator
    SRC_WDT = 2'b10, // watchdog timer oscillator
    SRC_EXT = 2'b11 // external clock input
  } ofdr_src_e;

  typedef enum logic [0:0] {
    SW_RUN = 1'b0, // clock gated on, source stable
    SW_GAP = 1'b1 // clock held low while the source changes
  } ofdr_sw_e;

  typedef struct packed {
    logic wdt_osc_en; // [5] watchdog oscillator running
    logic ipo_en; // [4] internal_precision_osc running
    logic wdt_osc_fail_detect_en; // [3] watchdog osc failure detection
    logic primary_fail_detect_en; // [2] primary osc failure detection
    ofdr_src_e osc_source_select; // [1:0] requested system clock source
  } ofdr_ctrl_s;

  typedef struct packed {
    logic wdt_fail; // [1] watchdog oscillator failed
    logic prim_fail; // [0] primary oscillator failed
  } ofdr_stat_s;

  localparam logic [1:0] SRC_NUM_W = 2'h3; // highest oscillator index
endpackage : ofdr_pkg
`default_nettype wire

// ---- hw/ofdr_sync2.sv ----
// two flip-flop synchroniser for the raw oscillator inputs
`default_nettype none
module ofdr_sync2 #(
  parameter int WIDTH = 4 // number of bits synchronised
) (
  input wire logic clk_i, // system clock
  input wire logic rst_i, // synchronous reset, active high
  input wire logic [WIDTH-1:0] d_i, // asynchronous inputs
  output logic [WIDTH-1:0] q_o // synchronised outputs
);
  // -----------------------------------------------------------------
  // stages
  // -----------------------------------------------------------------
  logic [WIDTH-1:0] meta_q; // first stage, read by the second only
  logic [WIDTH-1:0] sync_q; // second stage

  // two stages, nothing taps the first
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= d_i;
      sync_q <= meta_q;
    end
  end

  assign q_o = sync_q;
endmodule : ofdr_sync2
`default_nettype wire

// ---- hw/ofdr_top.sv ----
// oscillator failure detection and automatic clock recovery with a wishbone register port
// Behaviour
// - detection left on may flag during switch
// - internal oscillator on at reset, off only by software
// - primary failure raises nonmaskable event
// - primary failure forces watchdog oscillator as clock
// - forced switch only if watchdog oscillator enabled
// - no forced switch when watchdog is source
// - primary fails below about 1 khz
// - watchdog failure raises event, no clock change
// - after watchdog failure primary detection stops
// - watchdog fails after 8004 clocks without edge
//
// The Wishbone slave port and the address map are this design's own decisions.
`default_nettype none
module ofdr_top #(
  parameter logic [15:0] PRIM_FAIL_CYC = ofdr_pkg::PRIM_FAIL_CYC_DFLT, // clocks without a primary edge
  parameter logic [15:0] WDT_FAIL_CYC = ofdr_pkg::WDT_FAIL_CYC_DFLT // clocks without a wdt edge
) (
  input wire logic clk_i, // system clock, 10 mhz
  input wire logic rst_i, // synchronous reset, active high
  input wire logic [3:0] osc_i, // raw oscillator levels, indexed by source code
  input wire logic wb_cyc_i, // wishbone cycle
  input wire logic wb_stb_i, // wishbone strobe
  input wire logic wb_we_i, // wishbone write enable
  input wire logic [7:0] wb_adr_i, // wishbone byte address
  input wire logic [3:0] wb_sel_i, // wishbone byte lanes
  input wire logic [31:0] wb_dat_i, // wishbone write data
  output logic [31:0] wb_dat_o, // wishbone read data
  output logic wb_ack_o, // wishbone acknowledge
  output logic [1:0] clk_src_o, // active system clock source
  output logic clk_gate_o, // system clock gate, low during a change
  output logic ipo_en_o, // internal_precision_osc enable
  output logic wdt_osc_en_o, // watchdog oscillator enable
  output logic nmi_o, // nonmaskable failure event pending
  output logic irq_o // maskable interrupt line
);
  // -----------------------------------------------------------------
  // declarations
  // -----------------------------------------------------------------
  logic [3:0] osc_s; // synchronised oscillator levels
  logic [3:0] osc_prev_q; // previous levels for edge detect
  logic [3:0] osc_edge; // rising edges per source
  ofdr_pkg::ofdr_ctrl_s ctrl_q; // control register
  ofdr_pkg::ofdr_stat_s stat_q; // sticky failure flags
  ofdr_pkg::ofdr_stat_s ien_q; // interrupt enables
  ofdr_pkg::ofdr_stat_s clr_req; // write-one-to-clear this cycle
  ofdr_pkg::ofdr_src_e clk_src_q; // active clock source
  ofdr_pkg::ofdr_src_e target; // source the switcher heads for
  ofdr_pkg::ofdr_sw_e sw_state_q; // switcher state
  logic [3:0] gap_cnt_q; // cycles left in the gap
  logic clk_gate_q; // gate register
  logic forced_q; // recovery has taken over the clock
  logic wdt_dead_q; // a wdt failure has been seen
  logic [ofdr_pkg::CNT_W-1:0] prim_cnt_q; // clocks since last primary edge
  logic [ofdr_pkg::CNT_W-1:0] wdt_cnt_q; // clocks since last wdt edge
  logic prim_fail_evt; // one-cycle primary failure
  logic wdt_fail_evt; // one-cycle wdt failure
  logic prim_watch; // primary detector armed
  logic wdt_watch; // wdt detector armed
  logic switch_ok; // recovery may force a switch
  logic acc; // bus access this cycle
  logic wr_ctrl; // write to control register
  logic ack_q; // acknowledge register
  logic [31:0] dat_q; // read data register
  logic nmi_q; // nmi register
  logic irq_q; // irq register

  // -----------------------------------------------------------------
  // functions
  // -----------------------------------------------------------------
  // address match for a given register
  function automatic logic hit(input logic [7:0] adr, input logic [7:0] reg_adr);
    hit = (adr == reg_adr);
  endfunction : hit

  // read data for an address, unmapped reads give zero
  function automatic logic [31:0] rd_mux(input logic [7:0] adr, input ofdr_pkg::ofdr_ctrl_s c,
                                         input ofdr_pkg::ofdr_stat_s s, input ofdr_pkg::ofdr_stat_s e,
                                         input logic [ofdr_pkg::STATE_W-1:0] st);
    rd_mux = 32'h0;
    if (hit(adr, ofdr_pkg::ADR_CTRL)) begin
      rd_mux[ofdr_pkg::CTRL_W-1:0] = c;
    end else if (hit(adr, ofdr_pkg::ADR_STAT)) begin
      rd_mux[ofdr_pkg::STAT_W-1:0] = s;
    end else if (hit(adr, ofdr_pkg::ADR_IEN)) begin
      rd_mux[ofdr_pkg::STAT_W-1:0] = e;
    end else if (hit(adr, ofdr_pkg::ADR_STATE)) begin
      rd_mux[ofdr_pkg::STATE_W-1:0] = st;
    end
  endfunction : rd_mux

  // -----------------------------------------------------------------
  // oscillator inputs
  // -----------------------------------------------------------------
  ofdr_sync2 #(
    .WIDTH(4)
  ) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(osc_i),
    .q_o(osc_s)
  );

  // edge detect on the synchronised copies only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      osc_prev_q <= 4'h0;
    end else begin
      osc_prev_q <= osc_s;
    end
  end
  assign osc_edge = osc_s & ~osc_prev_q;

  // -----------------------------------------------------------------
  // wishbone slave
  // -----------------------------------------------------------------
  assign acc = wb_cyc_i && wb_stb_i && !ack_q;
  assign wr_ctrl = acc && wb_we_i && wb_sel_i[0] && hit(wb_adr_i, ofdr_pkg::ADR_CTRL);
  assign clr_req = (acc && wb_we_i && wb_sel_i[0] && hit(wb_adr_i, ofdr_pkg::ADR_CLR))
                   ? ofdr_pkg::ofdr_stat_s'(wb_dat_i[ofdr_pkg::STAT_W-1:0]) : ofdr_pkg::STAT_RST;

  // one ack per request, dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0;
    end else begin
      ack_q <= acc;
      if (acc && !wb_we_i) begin
        dat_q <= rd_mux(wb_adr_i, ctrl_q, stat_q, ien_q, {(sw_state_q == ofdr_pkg::SW_GAP), wdt_dead_q,
                                                        forced_q, clk_src_q});
      end
    end
  end

  // control register; oscillator enables only change by software
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= ofdr_pkg::CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_q <= ofdr_pkg::ofdr_ctrl_s'(wb_dat_i[ofdr_pkg::CTRL_W-1:0]);
    end
  end

  // interrupt enable register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ien_q <= ofdr_pkg::IEN_RST;
    end else if (acc && wb_we_i && wb_sel_i[0] && hit(wb_adr_i, ofdr_pkg::ADR_IEN)) begin
      ien_q <= ofdr_pkg::ofdr_stat_s'(wb_dat_i[ofdr_pkg::STAT_W-1:0]);
    end
  end

  // -----------------------------------------------------------------
  // primary oscillator failure detector
  // -----------------------------------------------------------------
  // watches whichever source drives the clock; no masking during a
  // software switch, so a left-on detector may fire then
  assign prim_watch = ctrl_q.primary_fail_detect_en && !wdt_dead_q;
  assign prim_fail_evt = prim_watch && (prim_cnt_q == PRIM_FAIL_CYC - 16'h1);
  // restarts on every rising edge of the active source
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prim_cnt_q <= '0;
    end else if (!prim_watch || osc_edge[clk_src_q] || prim_fail_evt) begin
      prim_cnt_q <= '0;
    end else begin
      prim_cnt_q <= prim_cnt_q + 16'h1;
    end
  end

  // -----------------------------------------------------------------
  // watchdog oscillator failure detector
  // -----------------------------------------------------------------
  // software must switch this off when wdt is the source or stopped
  assign wdt_watch = ctrl_q.wdt_osc_fail_detect_en && !wdt_dead_q;
  assign wdt_fail_evt = wdt_watch && (wdt_cnt_q == WDT_FAIL_CYC - 16'h1);
  // counts system clocks while waiting for a wdt edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wdt_cnt_q <= '0;
    end else if (!wdt_watch || osc_edge[ofdr_pkg::SRC_WDT] || wdt_fail_evt) begin
      wdt_cnt_q <= '0;
    end else begin
      wdt_cnt_q <= wdt_cnt_q + 16'h1;
    end
  end
  // a dead wdt blocks primary detection until reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wdt_dead_q <= 1'b0;
    end else if (wdt_fail_evt) begin
      wdt_dead_q <= 1'b1;
    end
  end

  // -----------------------------------------------------------------
  // recovery and glitch-free switch
  // -----------------------------------------------------------------
  assign switch_ok = ctrl_q.wdt_osc_en && (clk_src_q != ofdr_pkg::SRC_WDT);
  // forced takeover held until software next writes the control register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      forced_q <= 1'b0;
    end else if (prim_fail_evt && switch_ok) begin
      forced_q <= 1'b1;
    end else if (wr_ctrl) begin
      forced_q <= 1'b0;
    end
  end
  // wdt failure never alters the target
  assign target = forced_q ? ofdr_pkg::SRC_WDT : ctrl_q.osc_source_select;
  // break before make: gate low, wait, then move source and raise gate on the same edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sw_state_q <= ofdr_pkg::SW_RUN;
      clk_src_q <= ofdr_pkg::SRC_IPO;
      clk_gate_q <= 1'b1;
      gap_cnt_q <= 4'h0;
    end else begin
      case (sw_state_q)
        ofdr_pkg::SW_RUN: begin
          if (target != clk_src_q) begin
            clk_gate_q <= 1'b0;
            gap_cnt_q <= ofdr_pkg::SWITCH_GAP_CYC;
            sw_state_q <= ofdr_pkg::SW_GAP;
          end
        end
        ofdr_pkg::SW_GAP: begin
          if (gap_cnt_q == 4'h0) begin
            clk_src_q <= target;
            clk_gate_q <= 1'b1;
            sw_state_q <= ofdr_pkg::SW_RUN;
          end else begin
            gap_cnt_q <= gap_cnt_q - 4'h1;
          end
        end
        default: begin
          sw_state_q <= ofdr_pkg::SW_RUN;
        end
      endcase
    end
  end

  // -----------------------------------------------------------------
  // failure flags and interrupt outputs
  // -----------------------------------------------------------------
  // set beats clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stat_q <= ofdr_pkg::STAT_RST;
    end else begin
      stat_q.prim_fail <= prim_fail_evt || (stat_q.prim_fail && !clr_req.prim_fail);
      stat_q.wdt_fail <= wdt_fail_evt || (stat_q.wdt_fail && !clr_req.wdt_fail);
    end
  end
  // nmi ignores the mask, irq honours it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      nmi_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      nmi_q <= |stat_q;
      irq_q <= |(stat_q & ien_q);
    end
  end

  // -----------------------------------------------------------------
  // outputs
  // -----------------------------------------------------------------
  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;
  assign clk_src_o = clk_src_q;
  assign clk_gate_o = clk_gate_q;
  assign ipo_en_o = ctrl_q.ipo_en;
  assign wdt_osc_en_o = ctrl_q.wdt_osc_en;
  assign nmi_o = nmi_q;
  assign irq_o = irq_q;

  // -----------------------------------------------------------------
  // assertions
  // -----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_ack_pulse;
    ack_q |=> !ack_q;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held two cycles");
  property p_prim_flag;
    prim_fail_evt |=> stat_q.prim_fail ##1 nmi_q;
  endproperty
  a_prim_flag: assert property (p_prim_flag) else $error("primary failure not flagged");
  property p_force_switch;
    prim_fail_evt && switch_ok |-> ##[1:16] (clk_src_q == ofdr_pkg::SRC_WDT);
  endproperty
  a_force_switch: assert property (p_force_switch) else $error("no switch to wdt osc");
  property p_needs_wdt_en;
    prim_fail_evt && !ctrl_q.wdt_osc_en && !forced_q && !wr_ctrl |=> !forced_q;
  endproperty
  a_needs_wdt_en: assert property (p_needs_wdt_en) else $error("forced with wdt osc off");
  property p_not_from_wdt;
    $rose(forced_q) |-> $past(clk_src_q) != ofdr_pkg::SRC_WDT;
  endproperty
  a_not_from_wdt: assert property (p_not_from_wdt) else $error("forced while on wdt");
  property p_prim_count;
    prim_fail_evt |-> prim_cnt_q == PRIM_FAIL_CYC - 16'h1 ##1 prim_cnt_q == 16'h0;
  endproperty
  a_prim_count: assert property (p_prim_count) else $error("primary fail count wrong");
  property p_wdt_no_switch;
    wdt_fail_evt && !prim_fail_evt && !wr_ctrl |=> forced_q == $past(forced_q);
  endproperty
  a_wdt_no_switch: assert property (p_wdt_no_switch) else $error("wdt failure moved clock");
  // the counter may still hold a stale count in the first dead cycle
  property p_dead_blocks;
    wdt_dead_q |-> !prim_fail_evt ##1 prim_cnt_q == 16'h0;
  endproperty
  a_dead_blocks: assert property (p_dead_blocks) else $error("primary detect after wdt fail");
  property p_wdt_count;
    wdt_fail_evt |-> wdt_cnt_q == WDT_FAIL_CYC - 16'h1 ##1 wdt_dead_q;
  endproperty
  a_wdt_count: assert property (p_wdt_count) else $error("wdt fail count wrong");
  property p_gap_switch;
    $changed(clk_src_q) |-> !$past(clk_gate_q) && $past(clk_gate_q, 2) == 1'b0;
  endproperty
  a_gap_switch: assert property (p_gap_switch) else $error("source moved with clock on");
  property p_ipo_hold;
    $fell(ctrl_q.ipo_en) |-> $past(wr_ctrl);
  endproperty
  a_ipo_hold: assert property (p_ipo_hold) else $error("ipo stopped without write");
  property p_pending;
    stat_q.wdt_fail && !clr_req.wdt_fail |=> stat_q.wdt_fail;
  endproperty
  a_pending: assert property (p_pending) else $error("pending flag lost");
endmodule : ofdr_top
`default_nettype wire

// ---- verification/ofdr_tb.sv ----
// self-checking testbench for the oscillator failure detect and recovery block
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  // -----------------------------------------------------------------
  // stimulus and design signals
  // -----------------------------------------------------------------
  localparam int PF = 40; // shortened primary failure count
  localparam int WF = 30; // shortened watchdog failure count
  logic clk_i = 1'b0; // system clock
  logic rst_i = 1'b1; // synchronous reset
  logic [3:0] osc_i = 4'h0; // raw oscillator levels
  logic [3:0] osc_run = 4'hf; // which oscillators are alive
  int osc_cnt [4]; // half-period counters
  logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0; // bus request
  logic [7:0] wb_adr = 8'h00; // bus address
  logic [3:0] wb_sel = 4'h0; // byte lanes
  logic [31:0] wb_wdat = 32'h0; // write data
  logic [31:0] wb_rdat; // read data
  logic wb_ack, nmi_o, irq_o, clk_gate_o, ipo_en_o, wdt_osc_en_o; // outputs
  logic [1:0] clk_src_o, prev_src; // active source and its last value
  logic prev_gate; // gate level one cycle back
  int fail_count = 0; // mismatches
  int n_checks = 0; // comparisons
  int m_stat = 0; // model of the sticky status
  int m_ien = 0; // model of the interrupt enable
  int n; // cycle count of a wait
  logic [31:0] r; // scratch

  always #50 clk_i = ~clk_i; // 10 mhz

  ofdr_top #(.PRIM_FAIL_CYC(16'h0028), .WDT_FAIL_CYC(16'h001e)) i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .osc_i(osc_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat),
    .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .clk_src_o(clk_src_o), .clk_gate_o(clk_gate_o),
    .ipo_en_o(ipo_en_o), .wdt_osc_en_o(wdt_osc_en_o), .nmi_o(nmi_o), .irq_o(irq_o));

  // -----------------------------------------------------------------
  // oscillator sources: period of 8 clocks, a dead one sits low
  // -----------------------------------------------------------------
  always @(posedge clk_i) begin
    for (int i = 0; i < 4; i++) begin
      if (osc_run[i]) begin
        osc_cnt[i] = (osc_cnt[i] + 1) % 4;
        if (osc_cnt[i] == 0) osc_i[i] <= ~osc_i[i];
      end else begin
        osc_i[i] <= 1'b0; // stopped oscillator
      end
    end
  end

  // source may only move at the end of a gated gap, never under a running clock
  always @(posedge clk_i) begin
    if (!rst_i && clk_src_o !== prev_src) chk("gap_before_switch", 32'h0, {31'h0, prev_gate});
    prev_src <= clk_src_o;
    prev_gate <= clk_gate_o;
  end

  // -----------------------------------------------------------------
  // helpers
  // -----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
      fail_count++;
    end
  endtask : chk

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : report_and_stop

  // one classic cycle; called just after a rising edge
  task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int k;
    k = 0;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_wdat <= d;
    wb_sel <= 4'hf;
    do begin
      @(posedge clk_i);
      k++;
    end while (wb_ack !== 1'b1 && k < 50);
    q = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
    if (k >= 50) begin
      chk("ack_timeout", 32'h1, 32'h0);
      report_and_stop();
    end
    @(posedge clk_i); // bus idle for one cycle
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask : wr

  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    xfer(1'b0, a, 32'h0, q);
    chk(nm, exp, q);
  endtask : rdc

  // kind 0: wait for nmi, kind 1: wait for the given source
  task automatic wait_for(input int kind, input logic [1:0] v, output int cnt);
    cnt = 0;
    do begin
      @(posedge clk_i);
      cnt++;
    end while (!((kind == 0 && nmi_o === 1'b1) || (kind == 1 && clk_src_o === v)) && cnt < 300);
    if (cnt >= 300) begin
      chk("wait_timeout", 32'h1, 32'h0);
      report_and_stop();
    end
  endtask : wait_for

  task automatic chk_lines;
    chk("nmi", (m_stat != 0) ? 32'h1 : 32'h0, {31'h0, nmi_o});
    chk("irq", ((m_stat & m_ien) != 0) ? 32'h1 : 32'h0, {31'h0, irq_o});
    rdc("stat", ofdr_pkg::ADR_STAT, m_stat);
  endtask : chk_lines

  task automatic clear_all;
    wr(ofdr_pkg::ADR_CLR, 32'h3);
    m_stat = 0;
    @(posedge clk_i);
    chk_lines();
  endtask : clear_all

  // -----------------------------------------------------------------
  // main sequence
  // -----------------------------------------------------------------
  initial begin
    void'($urandom(32'h9223));
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    // reset values and refused accesses
    chk("ipo_en", 32'h1, {31'h0, ipo_en_o});
    chk("wdt_en", 32'h1, {31'h0, wdt_osc_en_o});
    rdc("ctrl_rst", ofdr_pkg::ADR_CTRL, 32'h30);
    wr(ofdr_pkg::ADR_STAT, 32'h3);
    wr(8'h14, 32'hff);
    rdc("unmapped", 8'h14, 32'h0);
    chk_lines();
    rdc("state_rst", ofdr_pkg::ADR_STATE, 32'h0);
    r = $urandom();
    wr(ofdr_pkg::ADR_IEN, r);
    m_ien = r & 3;
    rdc("ien", ofdr_pkg::ADR_IEN, m_ien);
    $display("reset and register test done");
    // primary failure with forced recovery to the watchdog oscillator
    wr(ofdr_pkg::ADR_IEN, 32'h1);
    m_ien = 1;
    wr(ofdr_pkg::ADR_CTRL, 32'h34);
    osc_run[0] = 1'b0;
    wait_for(0, 2'h0, n);
    chk("prim_latency_ok", 32'h1, (n >= PF - 4 && n <= PF + 8) ? 32'h1 : 32'h0);
    m_stat = 1;
    wait_for(1, 2'h2, n);
    chk("forced_src", 32'h2, {30'h0, clk_src_o});
    chk("ipo_kept", 32'h1, {31'h0, ipo_en_o});
    chk_lines();
    rdc("state_forced", ofdr_pkg::ADR_STATE, 32'h6);
    clear_all();
    $display("primary failure test done");
    // no forced switch while the watchdog oscillator is off
    osc_run[0] = 1'b1;
    wr(ofdr_pkg::ADR_CTRL, 32'h10);
    wait_for(1, 2'h0, n);
    wr(ofdr_pkg::ADR_CTRL, 32'h14);
    osc_run[0] = 1'b0;
    wait_for(0, 2'h0, n);
    m_stat = 1;
    repeat (20) @(posedge clk_i);
    chk("no_switch_wdt_off", 32'h0, {30'h0, clk_src_o});
    wr(ofdr_pkg::ADR_CTRL, 32'h10);
    clear_all();
    $display("disabled recovery test done");
    // no forced switch when the watchdog oscillator is the source
    osc_run[0] = 1'b1;
    wr(ofdr_pkg::ADR_CTRL, 32'h32);
    wait_for(1, 2'h2, n);
    wr(ofdr_pkg::ADR_CTRL, 32'h36);
    osc_run[2] = 1'b0;
    wait_for(0, 2'h0, n);
    m_stat = 1;
    repeat (20) @(posedge clk_i);
    chk("no_switch_wdt_src", 32'h2, {30'h0, clk_src_o});
    wr(ofdr_pkg::ADR_CTRL, 32'h32);
    clear_all();
    osc_run[2] = 1'b1;
    wr(ofdr_pkg::ADR_CTRL, 32'h30);
    wait_for(1, 2'h0, n);
    $display("watchdog source test done");
    // stalled external clock as source, primary detection kept off by software
    osc_run[3] = 1'b0;
    wr(ofdr_pkg::ADR_CTRL, 32'h33);
    wait_for(1, 2'h3, n);
    repeat (3 * PF) @(posedge clk_i);
    chk("ext_src", 32'h3, {30'h0, clk_src_o});
    chk_lines();
    wr(ofdr_pkg::ADR_CTRL, 32'h30);
    wait_for(1, 2'h0, n);
    osc_run[3] = 1'b1;
    $display("slow external clock test done");
    // watchdog oscillator failure
    wr(ofdr_pkg::ADR_CTRL, 32'h38);
    repeat (16) @(posedge clk_i);
    osc_run[2] = 1'b0;
    wait_for(0, 2'h0, n);
    chk("wdt_latency_ok", 32'h1, (n >= WF - 4 && n <= WF + 8) ? 32'h1 : 32'h0);
    m_stat = 2;
    chk_lines();
    rdc("state_dead", ofdr_pkg::ADR_STATE, 32'h8);
    wr(ofdr_pkg::ADR_CTRL, 32'h34);
    osc_run[0] = 1'b0;
    repeat (3 * PF) @(posedge clk_i);
    chk("src_kept", 32'h0, {30'h0, clk_src_o});
    chk_lines();
    wr(ofdr_pkg::ADR_CTRL, 32'h30);
    clear_all();
    $display("watchdog failure test done");
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire
